// [sar_pkg.sv]
// Shared constants and types for the converter control and read-out block.
// What this block does
// - Channel address is captured on each rising edge of convert start.
// - Address codes 00 to 11 select analog inputs zero to three.
// - A falling convert-start edge enters hold and begins a conversion.
// - All sixteen result lines stay undriven throughout a conversion.
// - Busy is high during conversion and drops when the result is ready.
// - Busy drops after the eighteenth conversion-clock rising edge.
// - Conversion clock is the external clock divided by 1, 2, 4 or 8.
// - Width select high gives an 8-bit bus, low gives 16 bits.
// - Sixteen-bit mode shows bits 15..0; byte mode shows bits 15..8 low.
// - Width select acts three clocks later; host may toggle it during one read.
// - Chip select and read strobe are active low; data drives when both low.
package sar_pkg;
    localparam int SAR_RES_W = 16;
    localparam int SAR_CH_W = 2;
    localparam int SAR_DIV_W = 2;
    localparam int SAR_CONVERT_START_N_CLKS = 18;
    localparam int SAR_FIFO_DEPTH = 32;
    localparam int SAR_HALF_W = SAR_RES_W / 2;
    localparam logic [SAR_RES_W-1:0] SAR_RES_RST = 16'h0000;

    typedef enum logic [1:0]
    {
        SAR_IDLE = 2'b00,
        SAR_WAIT = 2'b01,
        SAR_CONVERT_START_N = 2'b11
    } sar_state_t;

    // One finished conversion: the sample word and a channel field that the FIFO input ties to zero.
    typedef struct packed
    {
        logic [SAR_CH_W-1:0] channel;
        logic [SAR_RES_W-1:0] data;
    } sar_sample_t;

    typedef struct packed
    {
        logic [2:0] convert_start_n_s;
        logic [2:0] cs_s;
        logic [2:0] rd_s;
        logic [2:0] byte_s;
        logic [SAR_CH_W-1:0] ch0_s;
        logic [SAR_CH_W-1:0] ch1_s;
        logic [SAR_DIV_W-1:0] div0_s;
        logic [SAR_DIV_W-1:0] div1_s;
    } sar_sync_t;
endpackage : sar_pkg

// [sar_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides.
module sar_fifo
    import sar_pkg::*;
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("sar_fifo: depth must be a power of two >= 2");
    end

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sar_fifo_st_t;

    sar_fifo_st_t st;
    sar_fifo_st_t next_st;
    logic full;
    logic empty;

    assign full = (st.wr[AW] != st.rd[AW])
        && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign empty = st.wr == st.rd;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st.mem[st.rd[AW-1:0]];

    always_comb
    begin
        next_st = st;
        if (in_valid && !full)
        begin
            next_st.mem[st.wr[AW-1:0]] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (out_ready && !empty)
            next_st.rd = st.rd + 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end
endmodule : sar_fifo

// [sar_ctrl.sv]
// Conversion control and parallel tri-state read-out of the converter.
module sar_ctrl
    import sar_pkg::*;
#(
    parameter int CONVERT_START_N_CLKS = SAR_CONVERT_START_N_CLKS,
    parameter int FIFO_DEPTH = SAR_FIFO_DEPTH
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic CONVERT_START_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_N,
    input wire logic BYTE_MODE,
    input wire logic CHANNEL_SELECT_LOW_BIT,
    input wire logic CHANNEL_SELECT_HIGH_BIT,
    input wire logic [SAR_DIV_W-1:0] DIVIDER_SELECT,
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire logic [SAR_RES_W-1:0] SAMPLE_DATA,
    output logic [3:0] ANALOG_IN_SELECT,
    output logic HOLD,
    output logic BUSY,
    output logic [SAR_RES_W-1:0] RESULT_BUS_OUT,
    output logic [SAR_RES_W-1:0] RESULT_BUS_OE,
    output logic [SAR_CH_W-1:0] RESULT_CHANNEL
);
    initial
    begin
        if (CONVERT_START_N_CLKS < 1 || CONVERT_START_N_CLKS > 255)
            $error("sar_ctrl: CONVERT_START_N_CLKS must lie in 1..255");
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: the first stage is read only by the second.

    sar_sync_t sy;
    sar_sync_t next_sy;

    always_comb
    begin
        next_sy = sy;
        next_sy.convert_start_n_s = {sy.convert_start_n_s[1:0], CONVERT_START_N};
        next_sy.cs_s = {sy.cs_s[1:0], CHIP_SELECT_N};
        next_sy.rd_s = {sy.rd_s[1:0], READ_N};
        next_sy.byte_s = {sy.byte_s[1:0], BYTE_MODE};
        next_sy.ch0_s = {CHANNEL_SELECT_HIGH_BIT, CHANNEL_SELECT_LOW_BIT};
        next_sy.ch1_s = sy.ch0_s;
        next_sy.div0_s = DIVIDER_SELECT;
        next_sy.div1_s = sy.div0_s;
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            sy <= '1;
        else if (CE)
            sy <= next_sy;
    end

    logic convert_start_n_fall;
    logic convert_start_n_rise;
    logic cs_low;
    logic rd_low;
    logic byte_hi;

    assign convert_start_n_fall = sy.convert_start_n_s[2] && !sy.convert_start_n_s[1];
    assign convert_start_n_rise = !sy.convert_start_n_s[2] && sy.convert_start_n_s[1];
    assign cs_low = !sy.cs_s[1];
    assign rd_low = !sy.rd_s[1];
    assign byte_hi = sy.byte_s[1];

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock divider, sequencer and result holding.

    typedef struct packed
    {
        sar_state_t state;
        logic [2:0] div_cnt;
        logic [7:0] edges;
        logic [SAR_CH_W-1:0] addr;
        logic [SAR_CH_W-1:0] convert_start_n_ch;
        logic [SAR_RES_W-1:0] result;
        logic [SAR_CH_W-1:0] result_ch;
        logic [SAR_RES_W-1:0] bus;
        logic drive;
    } sar_st_t;

    sar_st_t st;
    sar_st_t next_st;
    logic [2:0] div_mask;
    logic tick;
    logic fifo_valid;
    sar_sample_t fifo_out;
    logic fifo_pop;

    always_comb
    begin
        case (sy.div1_s)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end

    // A conversion-clock rising edge falls on every divided wrap.
    assign tick = (st.div_cnt & div_mask) == div_mask;
    assign fifo_pop = st.state == SAR_CONVERT_START_N && st.edges == 8'(CONVERT_START_N_CLKS - 1)
        && tick && fifo_valid;

    always_comb
    begin
        next_st = st;
        next_st.div_cnt = st.div_cnt + 3'h1;
        if (convert_start_n_rise)
            next_st.addr = sy.ch1_s;
        case (st.state)
            SAR_IDLE:
            begin
                if (convert_start_n_fall)
                begin
                    next_st.state = SAR_CONVERT_START_N;
                    next_st.edges = 8'h00;
                    next_st.div_cnt = 3'h0;
                    next_st.convert_start_n_ch = st.addr;
                end
            end
            SAR_CONVERT_START_N:
            begin
                if (tick)
                begin
                    if (st.edges == 8'(CONVERT_START_N_CLKS - 1))
                    begin
                        if (fifo_valid)
                        begin
                            next_st.result = fifo_out.data;
                            next_st.result_ch = st.convert_start_n_ch;
                            next_st.state = SAR_IDLE;
                        end
                        else
                            next_st.state = SAR_WAIT;
                    end
                    else
                        next_st.edges = st.edges + 8'h01;
                end
            end
            SAR_WAIT:
            begin
                if (fifo_valid)
                begin
                    next_st.result = fifo_out.data;
                    next_st.result_ch = st.convert_start_n_ch;
                    next_st.state = SAR_IDLE;
                end
            end
            default: next_st.state = SAR_IDLE;
        endcase
        // Taken from the next state so the bus lets go on the edge BUSY rises.
        next_st.drive = cs_low && rd_low && next_st.state == SAR_IDLE;
        if (byte_hi)
            next_st.bus = {{SAR_HALF_W{1'b0}},
                next_st.result[SAR_RES_W-1:SAR_HALF_W]};
        else
            next_st.bus = next_st.result;
    end

    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            st <= '0;
            st.state <= SAR_IDLE;
            st.result <= SAR_RES_RST;
        end
        else if (CE)
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample buffer between the analog core and the sequencer.

    sar_sample_t fifo_in;
    logic fifo_wait_pop;

    assign fifo_in.channel = '0;
    assign fifo_in.data = SAMPLE_DATA;
    assign fifo_wait_pop = st.state == SAR_WAIT && fifo_valid;

    sar_fifo #(
        .WIDTH($bits(sar_sample_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(SAMPLE_VALID),
        .in_ready(SAMPLE_READY),
        .in_data(fifo_in),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop || fifo_wait_pop),
        .out_data(fifo_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    logic [SAR_CH_W-1:0] mux_ch;

    assign mux_ch = st.state == SAR_IDLE ? st.addr : st.convert_start_n_ch;

    always_comb
    begin
        ANALOG_IN_SELECT = 4'h0;
        ANALOG_IN_SELECT[mux_ch] = 1'b1;
    end

    assign HOLD = st.state != SAR_IDLE;
    assign BUSY = st.state != SAR_IDLE;
    assign RESULT_BUS_OUT = st.bus;
    // Byte mode leaves the upper lane undriven; a conversion keeps all off.
    assign RESULT_BUS_OE = !st.drive ? {SAR_RES_W{1'b0}}
        : sy.byte_s[2] ? {{SAR_HALF_W{1'b0}}, {SAR_HALF_W{1'b1}}}
        : {SAR_RES_W{1'b1}};
    assign RESULT_CHANNEL = st.result_ch;
endmodule : sar_ctrl

// [sar_ctrl_checker.sv]
// Port-level assertions for the converter control block.
module sar_ctrl_checker
    import sar_pkg::*;
#(
    parameter int CONVERT_START_N_CLKS = SAR_CONVERT_START_N_CLKS
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CONVERT_START_N,
    input wire logic CHIP_SELECT_N,
    input wire logic READ_N,
    input wire logic BYTE_MODE,
    input wire logic [SAR_DIV_W-1:0] DIVIDER_SELECT,
    input wire logic [3:0] ANALOG_IN_SELECT,
    input wire logic HOLD,
    input wire logic BUSY,
    input wire logic [SAR_RES_W-1:0] RESULT_BUS_OE
);
    default clocking
        @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    logic [11:0] busy_cnt;
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            busy_cnt <= 12'h000;
        else
            busy_cnt <= BUSY ? busy_cnt + 12'h001 : 12'h000;
    end
    property p_quiet;
        BUSY |-> RESULT_BUS_OE == 16'h0000;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus driven in conversion");
    // Hold starts only three edges after a real falling start edge.
    property p_hold;
        $rose(HOLD) |-> BUSY && $past(!CONVERT_START_N, 3)
            && $past(CONVERT_START_N, 4);
    endproperty
    a_hold: assert property (p_hold)
        else $error("hold entered without a start edge");
    property p_start;
        $fell(CONVERT_START_N) && !BUSY |-> ##[1:4] BUSY;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");
    property p_len;
        $fell(BUSY) |-> busy_cnt >= (CONVERT_START_N_CLKS << DIVIDER_SELECT);
    endproperty
    a_len: assert property (p_len)
        else $error("conversion too short");
    property p_sel;
        |RESULT_BUS_OE |-> $past(!CHIP_SELECT_N && !READ_N, 3);
    endproperty
    a_sel: assert property (p_sel)
        else $error("bus driven unselected");
    property p_byte;
        |RESULT_BUS_OE[15:8] |-> $past(!BYTE_MODE, 3);
    endproperty
    a_byte: assert property (p_byte)
        else $error("upper lines in byte mode");
    property p_oe;
        RESULT_BUS_OE inside {16'h0000, 16'h00FF, 16'hFFFF};
    endproperty
    a_oe: assert property (p_oe)
        else $error("bad enable pattern");
    property p_mux;
        $onehot(ANALOG_IN_SELECT);
    endproperty
    a_mux: assert property (p_mux)
        else $error("mux select not one-hot");
    c_done: cover property ($fell(BUSY));
    c_word: cover property (RESULT_BUS_OE == 16'hFFFF);
    c_byte: cover property (RESULT_BUS_OE == 16'h00FF);
endmodule : sar_ctrl_checker

bind sar_ctrl sar_ctrl_checker #(.CONVERT_START_N_CLKS(CONVERT_START_N_CLKS)) u_chk
(
    .SYS_CLK, .RST, .CONVERT_START_N, .CHIP_SELECT_N, .READ_N, .BYTE_MODE,
    .DIVIDER_SELECT, .ANALOG_IN_SELECT, .HOLD, .BUSY, .RESULT_BUS_OE
);

// [sar_src_model.sv]
// Behavioural analog core offering result words to the sample FIFO.
module sar_src_model
    import sar_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] limit,
    input wire logic ready,
    output logic valid,
    output logic [SAR_RES_W-1:0] data
);
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= 8'h00;
        else if (valid && ready)
            cnt <= cnt + 8'h01;
    end
    // Words stop at the bench limit; idle data is scrambled, never stale.
    assign valid = cnt < limit;
    assign data = valid ? 16'h1357 + {cnt, cnt} : ~(16'h1357 + {cnt, cnt});
endmodule : sar_src_model

// [sar_tb.sv]
// Self-checking bench for the converter control block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_pkg::*;
    logic clk = 1'b0, rst = 1'b1, convert_start_n_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1;
    logic byte_m = 1'b0, s_valid, s_ready, hold, busy;
    logic ce = 1'b1;
    logic [1:0] last_ch = 2'h0;
    logic [1:0] ch = 2'h0, div = 2'h0, rch;
    logic [7:0] limit = 8'h21;
    logic [3:0] sel;
    logic [15:0] s_data, bus_out, bus_oe;
    int n_fail = 0, checks = 0;
    sar_ctrl DUT (.SYS_CLK(clk), .RST(rst), .CE(ce), .CONVERT_START_N(convert_start_n_n),
        .CHIP_SELECT_N(cs_n), .READ_N(rd_n), .BYTE_MODE(byte_m),
        .CHANNEL_SELECT_LOW_BIT(ch[0]), .CHANNEL_SELECT_HIGH_BIT(ch[1]),
        .DIVIDER_SELECT(div), .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready),
        .SAMPLE_DATA(s_data), .ANALOG_IN_SELECT(sel), .HOLD(hold),
        .BUSY(busy), .RESULT_BUS_OUT(bus_out), .RESULT_BUS_OE(bus_oe),
        .RESULT_CHANNEL(rch));
    sar_src_model u_src (.clk(clk), .rst(rst), .limit(limit), .ready(s_ready),
        .valid(s_valid), .data(s_data));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic convert(input int c, input int d, input bit exact);
        int n;
        ch <= c[1:0];
        div <= d[1:0];
        cs_n <= 1'b0;
        repeat (20) @(posedge clk);
        convert_start_n_n <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (busy !== 1'b1 && n < 8);
        check(16'({hold, busy}), 16'h0003);
        check(16'(sel), 16'(4'h1 << last_ch));
        n = 1;
        while (n < 4000)
        begin
            check(bus_oe, 16'h0000);
            @(posedge clk);
            if (busy !== 1'b1)
                break;
            n++;
            if (n == 3)
                convert_start_n_n <= 1'b1;
            // A low clock enable freezes the conversion for five edges.
            if (n == 10)
                ce <= 1'b0;
            if (n == 15)
                ce <= 1'b1;
            if (!exact && n == 300)
                limit <= 8'h28;
        end
        if (exact)
            check(16'(n), 16'((SAR_CONVERT_START_N_CLKS << d) + 5));
        else
            check(16'(n > 300), 16'h0001);
        repeat (4) @(posedge clk);
        check(16'(sel), 16'(4'h1 << c));
        check(16'(rch), 16'(last_ch));
        last_ch = c[1:0];
    endtask : convert
    task automatic read_word(input logic [15:0] exp);
        cs_n <= 1'b0;
        @(posedge clk);
        rd_n <= 1'b0;
        repeat (5) @(posedge clk);
        check(bus_oe, 16'hFFFF);
        check(bus_out, exp);
        byte_m <= 1'b1;
        repeat (5) @(posedge clk);
        check(bus_oe, 16'h00FF);
        check({8'h00, bus_out[7:0]}, {8'h00, exp[15:8]});
        byte_m <= 1'b0;
        rd_n <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b1;
        repeat (5) @(posedge clk);
        check(bus_oe, 16'h0000);
    endtask : read_word
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial
    begin
        logic [7:0] k;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (60) @(posedge clk);
        check({busy, sel, bus_oe[10:0]}, 16'h0800);
        check(16'(s_ready), 16'h0000);
        // The core offers 33 words; the last conversion finds the FIFO empty.
        for (int i = 0; i < 34; i++)
        begin
            k = 8'(i);
            convert((i / 4) % 4, i % 4, i != 33);
            read_word(16'h1357 + {k, k});
            if (i == 0)
                read_word(16'h1357);
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule : tb
